/* File: verif/fcg_gpio_alarm_test.sv */
// Self-checking bench for the fan-control pin and alarm block over APB.
// Assumes fcg_pin_world closes the pin loop and one 10 MHz clock.
`timescale 1ns/10ps
`include "fcg_regs.svh"
module fcg_gpio_alarm_test;
  import fcg_pkg::*;
  logic             clk_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata_o;
  logic             pready_o;
  logic             pslverr_o;
  logic [4:0]       pin_level;
  logic [4:0]       pin_out_o;
  logic [4:0]       pin_oe_o;
  logic [4:0]       ext_low = 5'h00;
  fcg_byte_t        dac = 8'h80;
  logic [31:0]      tach = 32'h0;
  logic             osc = 1'b0;
  logic             full_on_o;
  logic             reg_clk_o;
  int               failures = 0;
  int               checks_done = 0;
  logic [31:0]      rd;
  logic             err;

  always #50 clk_i = ~clk_i;

  fcg_gpio_alarm fcg_gpio_alarm_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pin_in_i(pin_level), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .dac_value_i(dac), .tach_counts_i(tach), .osc_clk_i(osc), .full_on_o(full_on_o),
    .reg_clk_o(reg_clk_o)
  );

  fcg_pin_world fcg_pin_world_inst (.pin_oe_i(pin_oe_o), .ext_low_i(ext_low), .pin_level_o(pin_level));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= adr; pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0; penable <= 1'b0;
    if (pready_o !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: no pready", $time);
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    apb(1'b1, adr, wd);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    apb(1'b0, adr, 32'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, 32'h0, "slave error");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  logic [7:0] defs [2] = '{8'hAE, 8'h7B};
  logic [4:0] exts [2] = '{5'h02, 5'h01};
  logic [4:0] oes  [2] = '{5'h0D, 5'h12};
  logic [4:0] lvls [2] = '{5'h10, 5'h0C};

  initial begin
    cyc(12);
    chk(32'(pin_oe_o), 32'h0, "oe in reset");
    rstn_i <= 1'b1;
    rdchk(`FCG_OFS_PIN_DEF, 32'h0000_00FF);
    rdchk(`FCG_OFS_ALARM_EN, 32'h0);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    rdchk(`FCG_OFS_PIN_LEVEL, 32'h1F);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");

    for (int i = 0; i < 2; i++) begin
      wr(`FCG_OFS_PIN_DEF, {24'h0, defs[i]});
      ext_low <= exts[i];
      cyc(3);
      chk(32'(pin_oe_o), 32'(oes[i]), "pin drive");
      chk(32'(pin_out_o), 32'h0, "pin out level");
      wr(`FCG_OFS_PIN_LEVEL, 32'h0);
      rdchk(`FCG_OFS_PIN_LEVEL, 32'(lvls[i]));
      rdchk(`FCG_OFS_PIN_DEF, {24'h0, defs[i]});
    end
    ext_low <= 5'h00;
    $display("test pins done");

    wr(`FCG_OFS_PIN_DEF, 32'hFD);
    wr(`FCG_OFS_ALARM_EN, 32'h01);
    dac <= `FCG_DAC_MIN;
    cyc(4);
    chk(32'(pin_oe_o), 32'h01, "alert on min");
    rdchk(`FCG_OFS_ALARM_STAT, 32'h01);
    cyc(1);
    dac <= 8'h80;
    cyc(4);
    chk(32'(pin_oe_o), 32'h01, "alert held");
    rdchk(`FCG_OFS_ALARM_STAT, 32'h01);
    cyc(3);
    chk(32'(pin_oe_o), 32'h00, "alert cleared");
    rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    wr(`FCG_OFS_ALARM_EN, 32'h02);
    dac <= `FCG_DAC_MAX;
    cyc(4);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h02);
    cyc(3);
    chk(32'(pin_oe_o), 32'h01, "alert persists");
    wr(`FCG_OFS_ALARM_EN, 32'h00);
    cyc(3);
    chk(32'(pin_oe_o), 32'h00, "alert disabled");
    rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    dac <= 8'h80;
    $display("test output alarms done");

    wr(`FCG_OFS_ALARM_EN, 32'h04);
    for (int i = 0; i < 4; i++) begin
      tach <= 32'(`FCG_TACH_FULL) << (8 * i);
      cyc(3);
      chk(32'(pin_oe_o), 32'h01, "alert on overflow");
      tach <= 32'h0;
      cyc(2);
      rdchk(`FCG_OFS_ALARM_STAT, 32'h04);
      rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    end
    tach <= 32'hFEFE_FEFE;
    cyc(3);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    $display("test overflow done");

    wr(`FCG_OFS_ALARM_EN, 32'h18);
    ext_low <= 5'h02;
    cyc(3);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h08);
    ext_low <= 5'h06;
    cyc(3);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h18);
    cyc(1);
    ext_low <= 5'h04;
    cyc(3);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h18);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h10);
    cyc(1);
    ext_low <= 5'h00;
    cyc(3);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h10);
    rdchk(`FCG_OFS_ALARM_STAT, 32'h0);
    $display("test pin low alarms done");

    wr(`FCG_OFS_ALARM_EN, 32'h08);
    wr(`FCG_OFS_PIN_DEF, 32'hF7);
    ext_low <= 5'h02;
    cyc(3);
    chk(32'(full_on_o), 32'h1, "override on");
    rdchk(`FCG_OFS_ALARM_STAT, 32'h08);
    ext_low <= 5'h00;
    cyc(3);
    chk(32'(full_on_o), 32'h0, "override off");
    wr(`FCG_OFS_PIN_DEF, 32'hFF);
    ext_low <= 5'h02;
    cyc(3);
    chk(32'(full_on_o), 32'h0, "override unselected");
    ext_low <= 5'h00;
    wr(`FCG_OFS_ALARM_EN, 32'h00);
    $display("test override done");

    wr(`FCG_OFS_PIN_DEF, 32'hDF);
    for (int i = 0; i < 2; i++) begin
      osc <= ~osc;
      cyc(3);
      chk(32'(pin_oe_o[2]), {31'h0, ~osc}, "clock out pin");
      chk(32'(reg_clk_o), 32'(osc), "internal clock");
    end
    wr(`FCG_OFS_PIN_DEF, 32'hCF);
    osc <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      ext_low <= {2'h0, ~ext_low[2], 2'h0};
      cyc(3);
      chk(32'(reg_clk_o), {31'h0, ~ext_low[2]}, "clock in");
      chk(32'(pin_oe_o[2]), 32'h0, "clock in released");
    end
    ext_low <= 5'h00;
    $display("test clock done");
    complete_run();
  end
endmodule

/* File: verif/fcg_pin_world.sv */
// Far-side model of the five open-drain pins: pull-ups plus external pull-down sources.
// Assumes pin_oe_i high means the block pulls that wire low.
`timescale 1ns/10ps
module fcg_pin_world (
  input  wire logic [4:0] pin_oe_i,
  input  wire logic [4:0] ext_low_i,
  output logic      [4:0] pin_level_o
);
  // ---------------------------------------------------------------------------
  // Wired-and of all parties, pull-up when all release
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      pin_level_o[n] = ~(pin_oe_i[n] | ext_low_i[n]);
    end
  end
endmodule

/* File: verilog/fcg_alarm_bit.sv */
// One latched alarm: set by an enabled condition, cleared by a status read or by disabling.
// Assumes the clear request is a one-cycle pulse at the end of a status read.
`timescale 1ns/10ps
module fcg_alarm_bit (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic cond_i,
  input  wire logic en_i,
  input  wire logic clr_i,
  output logic      stat_o
);
  import fcg_pkg::*;

  fcg_alarm_s state_r;
  fcg_alarm_s state_nxt;

  // -------------------------------------------------------------------------
  // Sticky status, set wins over clear
  // -------------------------------------------------------------------------
  always_comb begin
    state_nxt      = state_r;
    state_nxt.stat = en_i & (cond_i | (state_r.stat & ~clr_i)); // R19 R20 R21
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign stat_o = state_r.stat;

endmodule

/* File: verilog/fcg_gpio_alarm.sv */
// Pin and alarm logic of a fan speed regulator: five open-drain pins, alert, override, clock sync.
// Assumes an APB master, pin levels and converter/tach values synchronous to clk_i.
//
// Overview of operation
// R1: Pins zero to two pull low when their two-bit field holds 10.
// R2: Pins zero to two release open-drain high when their field holds 11.
// R3: Pins three and four: field 0 pulls low, field 1 releases.
// R4: After reset every pin is released open-drain high.
// R5: Pin levels are readable; host releases a pin before using it as input.
// R6: Pin zero field 01 makes it the active-low alert output.
// R7: Alert pulls low whenever an enabled alarm is latched.
// R8: Pin one field 01 makes it the full-on override input.
// R9: Override input low forces maximum fan voltage whatever the mode.
// R10: Pin two field 01 drives out the internal regulation clock.
// R11: Pin two field 00 takes an external regulation clock instead.
// R12: Host ties clock pins, makes one source, matches loop settings.
// R13: Converter value 00h raises the minimum-output alarm.
// R14: Converter value FFh raises the maximum-output alarm.
// R15: Enable bits 0 and 1 enable minimum and maximum output alarms.
// R16: Any tach counter at 255 raises the overflow alarm.
// R17: Enable bit 2 lets the overflow alarm reach the alert.
// R18: Enable bits 3 and 4 alarm on pin one or two low.
// R19: A latched alarm holds the alert after its cause goes away.
// R20: A status read clears only alarms whose cause is gone.
// R21: Clearing an enable bit drops that alarm and its alert at once.
// R22: Tach counters are 8 bits and hold 255 after overflow.
// R23: Each status bit sits at its enable bit's position.
`timescale 1ns/10ps
`include "fcg_regs.svh"
module fcg_gpio_alarm (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [4:0]           pin_in_i,
  output logic [4:0]                pin_out_o,
  output logic [4:0]                pin_oe_o,
  input  wire fcg_pkg::fcg_byte_t   dac_value_i,
  input  wire logic [31:0]          tach_counts_i,
  input  wire logic                 osc_clk_i,
  output logic                      full_on_o,
  output logic                      reg_clk_o
);
  import fcg_pkg::*;

  fcg_top_s   state_r;
  fcg_top_s   state_nxt;
  logic [4:0] alarm_cond;
  logic [4:0] alarm_stat;
  logic [4:0] special_low;
  logic [1:0] pin_field [5];
  logic       bus_access;
  logic       bus_done;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic [1:0] field_of(input fcg_byte_t def, input int pos);
    logic [1:0] f;
    f = def[pos +: 2];
    return f;
  endfunction

  function automatic logic any_full(input logic [31:0] counts);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      hit = hit | (counts[i*8 +: 8] == `FCG_TACH_FULL);
    end
    return hit;
  endfunction

  // -------------------------------------------------------------------------
  // Alarm conditions
  // -------------------------------------------------------------------------
  always_comb begin
    alarm_cond                    = '0;
    alarm_cond[`FCG_ALM_MIN_OUT]  = (dac_value_i == `FCG_DAC_MIN);   // R13
    alarm_cond[`FCG_ALM_MAX_OUT]  = (dac_value_i == `FCG_DAC_MAX);   // R14
    alarm_cond[`FCG_ALM_TACH_OVF] = any_full(tach_counts_i);         // R16 R22
    alarm_cond[`FCG_ALM_OVR_LOW]  = ~pin_in_i[1];                    // R18
    alarm_cond[`FCG_ALM_SYNC_LOW] = ~pin_in_i[2];                    // R18
  end

  // Each latch gated by the enable bit at the same position
  for (genvar g = 0; g < 5; g++) begin : g_alarm
    fcg_alarm_bit u_alarm (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .cond_i (alarm_cond[g]),
      .en_i   (state_r.alarm_en[g]),     // R15 R17 R23
      .clr_i  (state_r.rd_clr[g]),
      .stat_o (alarm_stat[g])
    );
  end

  // -------------------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------------------
  always_comb begin
    special_low    = '0;
    special_low[0] = |(alarm_stat & state_r.alarm_en);  // R6 R7
    special_low[2] = ~osc_clk_i;                        // R10
    pin_field[0]   = field_of(state_r.pin_def, `FCG_POS_ALERT_PIN);
    pin_field[1]   = field_of(state_r.pin_def, `FCG_POS_OVR_PIN);
    pin_field[2]   = field_of(state_r.pin_def, `FCG_POS_SYNC_PIN);
    pin_field[3]   = {1'b1, state_r.pin_def[`FCG_POS_PLAIN_A]};  // R3
    pin_field[4]   = {1'b1, state_r.pin_def[`FCG_POS_PLAIN_B]};  // R3
  end

  for (genvar p = 0; p < 5; p++) begin : g_pin
    fcg_pin_drive u_pin (
      .clk_i         (clk_i),
      .rstn_i        (rstn_i),
      .field_i       (pin_field[p]),
      .special_low_i (special_low[p]),
      .oe_o          (pin_oe_o[p])
    );
  end

  // -------------------------------------------------------------------------
  // APB slave and control
  // -------------------------------------------------------------------------
  assign bus_access = psel_i & penable_i;
  assign bus_done   = bus_access & (state_r.st == FCG_ST_ACK);

  always_comb begin
    state_nxt         = state_r;
    state_nxt.rd_clr  = '0;
    state_nxt.pin_out = '0;
    state_nxt.full_on = (field_of(state_r.pin_def, `FCG_POS_OVR_PIN) == `FCG_CODE_SPECIAL)
                        & ~pin_in_i[1];                                   // R8 R9
    if (field_of(state_r.pin_def, `FCG_POS_SYNC_PIN) == `FCG_CODE_CLK_IN) begin
      state_nxt.reg_clk = pin_in_i[2];                                    // R11
    end else begin
      state_nxt.reg_clk = osc_clk_i;
    end
    case (state_r.st)
      FCG_ST_IDLE: begin
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (bus_access) begin
          state_nxt.st      = FCG_ST_ACK;
          state_nxt.pready  = 1'b1;
          state_nxt.prdata  = '0;
          case (paddr_i)
            `FCG_OFS_PIN_DEF:    state_nxt.prdata[7:0] = state_r.pin_def;
            `FCG_OFS_PIN_LEVEL:  state_nxt.prdata[4:0] = pin_in_i;            // R5
            `FCG_OFS_ALARM_EN:   state_nxt.prdata[4:0] = state_r.alarm_en;
            `FCG_OFS_ALARM_STAT: state_nxt.prdata[4:0] = alarm_stat;          // R23
            default:             state_nxt.pslverr     = 1'b1;
          endcase
        end
      end
      FCG_ST_ACK: begin
        state_nxt.st      = FCG_ST_IDLE;
        state_nxt.pready  = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (bus_done && pwrite_i) begin
          case (paddr_i)
            `FCG_OFS_PIN_DEF:  state_nxt.pin_def  = pwdata_i[7:0];
            `FCG_OFS_ALARM_EN: state_nxt.alarm_en = pwdata_i[4:0];           // R21
            default:           state_nxt.pin_def  = state_r.pin_def;
          endcase
        end
        if (bus_done && !pwrite_i && paddr_i == `FCG_OFS_ALARM_STAT) begin
          state_nxt.rd_clr = state_r.prdata[4:0];                            // R20
        end
      end
      default: begin
        state_nxt.st     = FCG_ST_IDLE;
        state_nxt.pready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r          <= '0;
      state_r.st       <= FCG_ST_IDLE;
      state_r.pin_def  <= `FCG_RST_PIN_DEF;   // R4
      state_r.alarm_en <= `FCG_RST_ALARM_EN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata_o  = state_r.prdata;
  assign pready_o  = state_r.pready;
  assign pslverr_o = state_r.pslverr;
  assign pin_out_o = state_r.pin_out;
  assign full_on_o = state_r.full_on;
  assign reg_clk_o = state_r.reg_clk;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_min_alarm;
    state_r.alarm_en[0] && dac_value_i == 8'h00;
  endsequence

  sequence s_alert_mode;
    state_r.pin_def[1:0] == 2'h1 && state_r.alarm_en[0];
  endsequence

  sequence s_idle_access;
    bus_access && state_r.st == FCG_ST_IDLE;
  endsequence

  a_drive_low_code: assert property (                                       // R1
    state_r.pin_def[1:0] == 2'h2 |=> pin_oe_o[0])
    else $error("pin zero not pulled low for code 10");

  a_release_high: assert property (                                         // R2
    state_r.pin_def[5:4] == 2'h3 |=> !pin_oe_o[2])
    else $error("pin two not released for code 11");

  a_plain_pin_low: assert property (                                        // R3
    !state_r.pin_def[6] |=> pin_oe_o[3])
    else $error("plain pin a not pulled low for code 0");

  a_min_alarm_set: assert property (                                        // R13
    s_min_alarm |=> alarm_stat[0])
    else $error("minimum output alarm not latched");

  a_max_alarm_set: assert property (                                        // R14
    state_r.alarm_en[1] && dac_value_i == 8'hFF |=> alarm_stat[1])
    else $error("maximum output alarm not latched");

  a_tach_ovf_set: assert property (                                         // R16
    state_r.alarm_en[2] && tach_counts_i[15:8] == 8'hFF |=> alarm_stat[2])
    else $error("tach overflow alarm not latched");

  a_pin_low_alarm: assert property (                                        // R18
    state_r.alarm_en[4] && !pin_in_i[2] |=> alarm_stat[4])
    else $error("pin two low alarm not latched");

  a_alert_pulls_low: assert property (                                      // R7
    s_alert_mode ##0 s_min_alarm ##1 $stable(state_r.pin_def) && state_r.alarm_en[0] |=> pin_oe_o[0])
    else $error("alert pin not pulled low after enabled alarm");

  a_alert_sticky: assert property (                                         // R19
    alarm_stat[3] && state_r.alarm_en[3] && !state_r.rd_clr[3] |=> alarm_stat[3])
    else $error("latched alarm dropped without a clear");

  a_read_keeps: assert property (                                           // R20
    (state_r.rd_clr[0] and s_min_alarm) |=> alarm_stat[0])
    else $error("status read cleared an alarm whose cause persists");

  a_disable_clears: assert property (                                       // R21
    !state_r.alarm_en[1] |=> !alarm_stat[1] ##1
      (!pin_oe_o[0] || $past(state_r.alarm_en) != 5'h00 || $past(state_r.pin_def[1:0]) != 2'h1))
    else $error("disabled alarm still latched");

  a_override_on: assert property (                                          // R9
    state_r.pin_def[3:2] == 2'h1 && !pin_in_i[1] |=> full_on_o)
    else $error("override input low did not force full on");

  a_ext_clock: assert property (                                            // R11
    state_r.pin_def[5:4] == 2'h0 |=> reg_clk_o == $past(pin_in_i[2]))
    else $error("external clock not selected");

  a_alert_idle: assert property ( // R6
    state_r.pin_def[1:0] == 2'h1 && (alarm_stat & state_r.alarm_en) == 5'h00 |=> !pin_oe_o[0])
    else $error("alert pin pulled low with no enabled alarm");

  a_pin1_low_code: assert property ( // R1
    state_r.pin_def[3:2] == 2'h2 |=> pin_oe_o[1])
    else $error("pin one not pulled low for code 10");

  a_pin2_low_code: assert property ( // R1
    state_r.pin_def[5:4] == 2'h2 |=> pin_oe_o[2])
    else $error("pin two not pulled low for code 10");

  a_pin0_release: assert property ( // R2
    state_r.pin_def[1:0] == 2'h3 |=> !pin_oe_o[0])
    else $error("pin zero not released for code 11");

  a_pin1_release: assert property ( // R2
    state_r.pin_def[3:2] == 2'h3 |=> !pin_oe_o[1])
    else $error("pin one not released for code 11");

  a_plain_b_low: assert property ( // R3
    !state_r.pin_def[7] |=> pin_oe_o[4])
    else $error("plain pin b not pulled low for code 0");

  a_plain_release: assert property ( // R3
    state_r.pin_def[7:6] == 2'h3 |=> pin_oe_o[4:3] == 2'h0)
    else $error("plain pins not released for code 1");

  a_clock_out: assert property ( // R10
    state_r.pin_def[5:4] == 2'h1 |=> pin_oe_o[2] == !$past(osc_clk_i))
    else $error("pin two does not follow the internal clock");

  a_int_clock: assert property ( // R11
    state_r.pin_def[5:4] != 2'h0 |=> reg_clk_o == $past(osc_clk_i))
    else $error("internal clock not selected");

  a_override_off: assert property ( // R8
    state_r.pin_def[3:2] != 2'h1 |=> !full_on_o)
    else $error("full on forced while override not selected");

  a_tach_disable: assert property ( // R21
    !state_r.alarm_en[2] |=> !alarm_stat[2])
    else $error("disabled overflow alarm still latched");

  a_pin_disable: assert property ( // R21
    !state_r.alarm_en[3] |=> !alarm_stat[3])
    else $error("disabled pin one alarm still latched");

  a_tach0_ovf: assert property ( // R16
    state_r.alarm_en[2] && tach_counts_i[7:0] == 8'hFF |=> alarm_stat[2])
    else $error("first tach overflow not latched");

  a_tach3_ovf: assert property ( // R22
    state_r.alarm_en[2] && tach_counts_i[31:24] == 8'hFF |=> alarm_stat[2])
    else $error("last tach overflow not latched");

  a_pin1_alarm: assert property ( // R18
    state_r.alarm_en[3] && !pin_in_i[1] |=> alarm_stat[3])
    else $error("pin one low alarm not latched");

  a_read_clears: assert property ( // R20
    state_r.rd_clr[3] && pin_in_i[1] |=> !alarm_stat[3])
    else $error("status read kept an alarm whose cause is gone");

  a_min_needs_cause: assert property ( // R13
    !alarm_stat[0] && dac_value_i != 8'h00 |=> !alarm_stat[0])
    else $error("minimum output alarm set without cause");

  a_max_sticky: assert property ( // R19
    alarm_stat[1] && state_r.alarm_en[1] && !state_r.rd_clr[1] |=> alarm_stat[1])
    else $error("maximum output alarm dropped without a clear");

  a_level_read: assert property ( // R5
    s_idle_access ##0 paddr_i == `FCG_OFS_PIN_LEVEL |=> prdata_o[4:0] == $past(pin_in_i))
    else $error("pin level read returned wrong levels");

  a_status_read: assert property ( // R23
    s_idle_access ##0 paddr_i == `FCG_OFS_ALARM_STAT |=> prdata_o[4:0] == $past(alarm_stat))
    else $error("status read returned wrong bits");

endmodule

/* File: verilog/fcg_pin_drive.sv */
// One open-drain pin driver: decodes a two-bit pin field into a registered pull-low enable.
// Assumes the field and the special-function request are synchronous to clk_i.
`timescale 1ns/10ps
`include "fcg_regs.svh"
module fcg_pin_drive (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] field_i,
  input  wire logic       special_low_i,
  output logic            oe_o
);
  import fcg_pkg::*;

  fcg_pin_s state_r;
  fcg_pin_s state_nxt;

  // -------------------------------------------------------------------------
  // Field decode
  // -------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (field_i)
      `FCG_CODE_LOW:     state_nxt.oe = 1'b1;          // R1
      `FCG_CODE_HIGH:    state_nxt.oe = 1'b0;          // R2
      `FCG_CODE_SPECIAL: state_nxt.oe = special_low_i;
      default:           state_nxt.oe = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= '0;                                   // R4
    end else begin
      state_r <= state_nxt;
    end
  end

  assign oe_o = state_r.oe;

endmodule

/* File: verilog/fcg_pkg.sv */
// Types shared by the fan-control pin and alarm block.
// Assumes fcg_regs.svh for the numeric constants.
package fcg_pkg;

  // -------------------------------------------------------------------------
  // Bus slave states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCG_ST_IDLE = 2'h1,
    FCG_ST_ACK  = 2'h2
  } fcg_bus_state_e;

  typedef logic [7:0] fcg_byte_t;

  // -------------------------------------------------------------------------
  // Module state records
  // -------------------------------------------------------------------------
  typedef struct packed {
    fcg_bus_state_e st;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    fcg_byte_t      pin_def;
    logic [4:0]     alarm_en;
    logic [4:0]     rd_clr;
    logic           full_on;
    logic           reg_clk;
    logic [4:0]     pin_out;
  } fcg_top_s;

  typedef struct packed {
    logic stat;
  } fcg_alarm_s;

  typedef struct packed {
    logic oe;
  } fcg_pin_s;

endpackage

/* File: verilog/fcg_regs.svh */
// Register offsets, field positions, reset values and codes of the fan-control pin and alarm block.
// Assumes byte addresses on an APB bus with 32-bit data, one word per register.
`ifndef FCG_REGS_SVH
`define FCG_REGS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define FCG_OFS_PIN_DEF     8'h00
`define FCG_OFS_PIN_LEVEL   8'h04
`define FCG_OFS_ALARM_EN    8'h08
`define FCG_OFS_ALARM_STAT  8'h0C

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define FCG_RST_PIN_DEF     8'hFF
`define FCG_RST_ALARM_EN    5'h00

// ---------------------------------------------------------------------------
// Pin definition field positions
// ---------------------------------------------------------------------------
`define FCG_POS_ALERT_PIN   0
`define FCG_POS_OVR_PIN     2
`define FCG_POS_SYNC_PIN    4
`define FCG_POS_PLAIN_A     6
`define FCG_POS_PLAIN_B     7

// ---------------------------------------------------------------------------
// Two-bit field codes and alarm bit positions
// ---------------------------------------------------------------------------
`define FCG_CODE_SPECIAL    2'h1
`define FCG_CODE_CLK_IN     2'h0
`define FCG_CODE_LOW        2'h2
`define FCG_CODE_HIGH       2'h3
`define FCG_ALM_MIN_OUT     0
`define FCG_ALM_MAX_OUT     1
`define FCG_ALM_TACH_OVF    2
`define FCG_ALM_OVR_LOW     3
`define FCG_ALM_SYNC_LOW    4
`define FCG_DAC_MIN         8'h00
`define FCG_DAC_MAX         8'hFF
`define FCG_TACH_FULL       8'hFF

`endif
